// [rtl/ctc_regs.svh]
// Register map, field positions and timing counts of the cassette transport control
// Functional notes
// - Line A only drives capstan forward
// - Line B only drives capstan backward
// - Both lines high brake capstan terminals
// - Both lines low float the capstan
// - Regulated capstan speed while reading or writing
// - Speed regulation switchable, off when fast
// - Ten-pole tachometer gives nominal frequency
// - Four count pulses per reel turn
// - Head command high powers pinch motor
// - Head command low brakes pinch motor
// - Cam switch reports head position
// - Erase command low drives erase winding
// - Write current reverses on each edge
`ifndef CTC_REGS_SVH
`define CTC_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define CTC_CTRL_OFS      12'h000
`define CTC_STATUS_OFS    12'h004
`define CTC_TACHO_OFS     12'h008
`define CTC_COUNT_OFS     12'h00C
`define CTC_SPEED_OFS     12'h010

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTC_CTRL_LINE_A   0
`define CTC_CTRL_LINE_B   1
`define CTC_CTRL_FAST     2
`define CTC_CTRL_HEAD     3
`define CTC_CTRL_ERASE_N  4
`define CTC_CTRL_WBIT     5
`define CTC_CTRL_REG_EN   6
`define CTC_CTRL_CNT_CLR  7
`define CTC_CTRL_RST      32'h0000_0010

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define CTC_ST_FWD        0
`define CTC_ST_BWD        1
`define CTC_ST_BRAKE      2
`define CTC_ST_FLOAT      3
`define CTC_ST_HEAD_SW    4
`define CTC_ST_SPEED_OK   5
`define CTC_ST_WCUR       6
`define CTC_ST_HEAD_RUN   7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CTC_CLK_HZ        100000000
`define CTC_TACHO_HZ      400
`define CTC_TACHO_POLES   10
`define CTC_CAPSTAN_RPM   2400
`define CTC_REELS_MIRRORS 4
`define CTC_TACHO_CYC     (`CTC_CLK_HZ / `CTC_TACHO_HZ)
`define CTC_TACHO_TOL     32'd2500

`endif

// [rtl/ctc_pkg.sv]
// Types shared by the cassette transport control
package ctc_pkg;
    typedef enum logic [1:0] {
        CTC_FLOAT,
        CTC_FWD,
        CTC_BWD,
        CTC_BRAKE
    } ctc_drive_e;
    typedef logic [31:0] ctc_word_t;
endpackage

// [rtl/ctc_transport.sv]
// Cassette transport control: capstan bridge, speed loop, head motor, erase, write current
`timescale 1ns/1ns
`include "ctc_regs.svh"

module ctc_transport #(
    parameter int unsigned TACHO_CYC = `CTC_TACHO_CYC,
    parameter int unsigned TACHO_TOL = `CTC_TACHO_TOL
) (
    input  wire logic              clk_sys_in,
    input  wire logic              rst_in,
    input  wire logic              hsel_in,
    input  wire logic [31:0]       haddr_in,
    input  wire logic [1:0]        htrans_in,
    input  wire logic              hwrite_in,
    input  wire logic [2:0]        hsize_in,
    input  wire ctc_pkg::ctc_word_t hwdata_in,
    input  wire logic              hready_in,
    output ctc_pkg::ctc_word_t     hrdata_out,
    output logic                   hreadyout_out,
    output logic                   hresp_out,
    input  wire logic              tacho_in,
    input  wire logic              reel_mirror_in,
    input  wire logic              head_cam_in,
    output logic                   capstan_pos_hi_out,
    output logic                   capstan_pos_lo_out,
    output logic                   capstan_neg_hi_out,
    output logic                   capstan_neg_lo_out,
    output logic                   capstan_supply_out,
    output logic                   head_motor_drive_out,
    output logic                   head_motor_brake_out,
    output logic                   erase_drive_out,
    output logic                   write_current_dir_out,
    output logic                   tape_count_pulse_out,
    output logic                   head_position_switch_out
);
    import ctc_pkg::*;

    // A short period leaves no room to tell fast from slow
    if (TACHO_CYC < 16 || TACHO_TOL >= TACHO_CYC) begin : g_bad_tacho
        $error("ctc_transport: tacho period or tolerance out of range");
    end

    // ----------------------------------------
    // Input synchronisers, one per pin
    // ----------------------------------------
    logic [2:0] pins;
    logic [2:0] sync2_ff;
    logic [2:0] prev_ff;

    assign pins = {head_cam_in, reel_mirror_in, tacho_in};

    // Only the second stage is read; the third stage serves the edge detectors alone
    for (genvar g = 0; g < 3; g++) begin : g_sync
        logic stage1_ff;
        logic stage2_ff;
        logic stage3_ff;
        logic nxt_stage1;
        logic nxt_stage2;
        logic nxt_stage3;

        always_comb begin
            nxt_stage1 = pins[g];
            nxt_stage2 = stage1_ff;
            nxt_stage3 = stage2_ff;
        end

        always_ff @(posedge clk_sys_in) begin
            if (rst_in) begin
                stage1_ff <= 1'b0;
                stage2_ff <= 1'b0;
                stage3_ff <= 1'b0;
            end else begin
                stage1_ff <= nxt_stage1;
                stage2_ff <= nxt_stage2;
                stage3_ff <= nxt_stage3;
            end
        end

        assign sync2_ff[g] = stage2_ff;
        assign prev_ff[g]  = stage3_ff;
    end

    // Detectors start low: a pin already high at reset release counts as one edge
    logic tacho_rise;
    logic mirror_rise;
    assign tacho_rise  = sync2_ff[0] & ~prev_ff[0];
    assign mirror_rise = sync2_ff[1] & ~prev_ff[1];

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    logic        wr_pend_ff;
    logic        nxt_wr_pend;
    logic [11:0] addr_ff;
    logic [11:0] nxt_addr;
    ctc_word_t   ctrl_ff;
    ctc_word_t   nxt_ctrl;
    ctc_word_t   rdata_ff;
    ctc_word_t   nxt_rdata;
    logic [31:0] count_ff;
    logic [31:0] nxt_count;
    logic [31:0] period_ff;
    logic [31:0] nxt_period;
    logic [31:0] tcnt_ff;
    logic [31:0] nxt_tcnt;
    logic        speed_ok_ff;
    logic        nxt_speed_ok;
    logic        speed_ok;
    ctc_word_t   status;
    logic        addr_phase;

    // Read data is fetched at the address phase so it stands through a zero-wait data phase
    assign addr_phase = hsel_in & hready_in & htrans_in[1];

    always_comb begin
        nxt_wr_pend = addr_phase & hwrite_in;
        nxt_addr    = addr_phase ? haddr_in[11:0] : addr_ff;
        nxt_ctrl    = ctrl_ff;
        // Only the eight control bits are kept; the rest read back as zero
        if (wr_pend_ff && addr_ff == `CTC_CTRL_OFS) begin
            nxt_ctrl = {24'h0, hwdata_in[7:0]};
        end
        nxt_rdata = 32'h0;
        if (addr_phase && !hwrite_in) begin
            unique case (haddr_in[11:0])
                `CTC_CTRL_OFS:   nxt_rdata = ctrl_ff;
                `CTC_STATUS_OFS: nxt_rdata = status;
                `CTC_TACHO_OFS:  nxt_rdata = period_ff;
                `CTC_COUNT_OFS:  nxt_rdata = count_ff;
                `CTC_SPEED_OFS:  nxt_rdata = TACHO_CYC;
                default:         nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            wr_pend_ff <= 1'b0;
            addr_ff    <= 12'h000;
            ctrl_ff    <= `CTC_CTRL_RST;
            rdata_ff   <= 32'h0;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            addr_ff    <= nxt_addr;
            ctrl_ff    <= nxt_ctrl;
            rdata_ff   <= nxt_rdata;
        end
    end

    // ----------------------------------------
    // Bus response: never stalls, never errors
    // ----------------------------------------
    logic hready_ff;
    logic nxt_hready;
    logic hresp_ff;
    logic nxt_hresp;

    always_comb begin
        nxt_hready = 1'b1;
        nxt_hresp  = 1'b0;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            hready_ff <= 1'b1;
            hresp_ff  <= 1'b0;
        end else begin
            hready_ff <= nxt_hready;
            hresp_ff  <= nxt_hresp;
        end
    end

    assign hrdata_out    = rdata_ff;
    assign hreadyout_out = hready_ff;
    assign hresp_out     = hresp_ff;

    // ----------------------------------------
    // Capstan bridge decode
    // ----------------------------------------
    ctc_drive_e drive;
    always_comb begin
        unique case ({ctrl_ff[`CTC_CTRL_LINE_B], ctrl_ff[`CTC_CTRL_LINE_A]})
            2'b01: drive = CTC_FWD;
            2'b10: drive = CTC_BWD;
            2'b11: drive = CTC_BRAKE;
            2'b00: drive = CTC_FLOAT;
        endcase
    end

    // ----------------------------------------
    // Speed loop: measure tacho period, gate supply
    // ----------------------------------------
    logic reg_en;
    assign reg_en = ctrl_ff[`CTC_CTRL_REG_EN] & ~ctrl_ff[`CTC_CTRL_FAST];

    always_comb begin
        nxt_tcnt     = tcnt_ff + 32'd1;
        nxt_period   = period_ff;
        nxt_speed_ok = speed_ok_ff;
        if (tacho_rise) begin
            nxt_tcnt     = 32'd1;
            nxt_period   = tcnt_ff;
            nxt_speed_ok = (tcnt_ff + TACHO_TOL >= TACHO_CYC) && (tcnt_ff <= TACHO_CYC + TACHO_TOL);
        // Hold the count once overdue so a stalled motor never wraps back into range
        end else if (tcnt_ff > TACHO_CYC + TACHO_TOL) begin
            nxt_tcnt     = tcnt_ff;
            nxt_speed_ok = 1'b0;
        end
        nxt_count = count_ff;
        if (ctrl_ff[`CTC_CTRL_CNT_CLR]) begin
            nxt_count = 32'h0;
        end else if (mirror_rise) begin
            nxt_count = count_ff + 32'd1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            tcnt_ff     <= 32'h0;
            period_ff   <= 32'h0;
            speed_ok_ff <= 1'b0;
            count_ff    <= 32'h0;
        end else begin
            tcnt_ff     <= nxt_tcnt;
            period_ff   <= nxt_period;
            speed_ok_ff <= nxt_speed_ok;
            count_ff    <= nxt_count;
        end
    end

    // Too slow means supply on; too fast (short period) means supply off
    // regulated supply gating
    assign speed_ok = speed_ok_ff | (tcnt_ff > TACHO_CYC);

    // ----------------------------------------
    // Output drivers, all registered
    // ----------------------------------------
    logic [10:0] out_ff;
    logic [10:0] nxt_out;
    logic        wcur_ff;
    logic        nxt_wcur;
    logic        wbit_prev_ff;
    logic        nxt_wbit_prev;

    always_comb begin
        nxt_out = 11'h0;
        // At most one switch per terminal closes, so there is no shoot-through path
        nxt_out[0] = (drive == CTC_FWD);
        nxt_out[1] = (drive == CTC_BWD) || (drive == CTC_BRAKE);
        nxt_out[2] = (drive == CTC_BWD);
        nxt_out[3] = (drive == CTC_FWD) || (drive == CTC_BRAKE);
        nxt_out[4] = ((drive == CTC_FWD) || (drive == CTC_BWD)) && (!reg_en || speed_ok);
        nxt_out[5] = ctrl_ff[`CTC_CTRL_HEAD];
        // Brake whenever not driven, so the head never coasts off position
        // head motor brake
        nxt_out[6] = ~ctrl_ff[`CTC_CTRL_HEAD];
        nxt_out[7] = ~ctrl_ff[`CTC_CTRL_ERASE_N];
        nxt_out[8] = mirror_rise;
        nxt_out[9] = sync2_ff[2];
        nxt_out[10] = 1'b0;
        nxt_wcur = wcur_ff ^ (ctrl_ff[`CTC_CTRL_WBIT] ^ wbit_prev_ff);
        nxt_wbit_prev = ctrl_ff[`CTC_CTRL_WBIT];
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            out_ff       <= 11'h0;
            wcur_ff      <= 1'b0;
            wbit_prev_ff <= 1'b0;
        end else begin
            out_ff       <= nxt_out;
            wcur_ff      <= nxt_wcur;
            wbit_prev_ff <= nxt_wbit_prev;
        end
    end

    assign capstan_pos_hi_out       = out_ff[0];
    assign capstan_pos_lo_out       = out_ff[1];
    assign capstan_neg_hi_out       = out_ff[2];
    assign capstan_neg_lo_out       = out_ff[3];
    assign capstan_supply_out       = out_ff[4];
    assign head_motor_drive_out     = out_ff[5];
    assign head_motor_brake_out     = out_ff[6];
    assign erase_drive_out          = out_ff[7];
    assign tape_count_pulse_out     = out_ff[8];
    assign head_position_switch_out = out_ff[9];
    assign write_current_dir_out    = wcur_ff;

    always_comb begin
        // Decoded state, so it leads the bridge pins by one clock
        status = 32'h0;
        status[`CTC_ST_FWD]      = (drive == CTC_FWD);
        status[`CTC_ST_BWD]      = (drive == CTC_BWD);
        status[`CTC_ST_BRAKE]    = (drive == CTC_BRAKE);
        status[`CTC_ST_FLOAT]    = (drive == CTC_FLOAT);
        status[`CTC_ST_HEAD_SW]  = sync2_ff[2];
        status[`CTC_ST_SPEED_OK] = speed_ok_ff;
        status[`CTC_ST_WCUR]     = wcur_ff;
        status[`CTC_ST_HEAD_RUN] = out_ff[5];
    end
endmodule

// [sim/ctc_transport_props.sv]
// Port assertions for the transport control
`timescale 1ns/1ns
module ctc_transport_props (
    input wire logic               clk_sys_in,
    input wire logic               rst_in,
    input wire logic               hsel_in,
    input wire logic [31:0]        haddr_in,
    input wire logic [1:0]         htrans_in,
    input wire logic               hwrite_in,
    input wire ctc_pkg::ctc_word_t hwdata_in,
    input wire logic               hready_in,
    input wire logic               reel_mirror_in,
    input wire logic               capstan_pos_hi_out,
    input wire logic               capstan_pos_lo_out,
    input wire logic               capstan_neg_hi_out,
    input wire logic               capstan_neg_lo_out,
    input wire logic               head_motor_drive_out,
    input wire logic               head_motor_brake_out,
    input wire logic               erase_drive_out,
    input wire logic               write_current_dir_out,
    input wire logic               tape_count_pulse_out
);
    import ctc_pkg::*;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic       wr_ff, nxt_wr, wb_ff, nxt_wb;
    logic [7:0] d;
    logic [3:0] br;
    assign d  = hwdata_in[7:0];
    assign br = {capstan_pos_hi_out, capstan_pos_lo_out, capstan_neg_hi_out, capstan_neg_lo_out};
    // Data phase of a control write, and the write bit it last stored
    always_comb begin
        nxt_wr = hsel_in & hready_in & htrans_in[1] & hwrite_in & (haddr_in[11:0] == 12'h000);
        nxt_wb = wr_ff ? d[5] : wb_ff;
    end
    always_ff @(posedge clk_sys_in) begin
        wr_ff <= rst_in ? 1'b0 : nxt_wr;
        wb_ff <= rst_in ? 1'b0 : nxt_wb;
    end
    a_fwd_bridge: assert property (wr_ff && d[1:0] == 2'h1 |-> ##2 br == 4'h9)
        else $error("forward bridge wrong");
    a_bwd_bridge: assert property (wr_ff && d[1:0] == 2'h2 |-> ##2 br == 4'h6)
        else $error("backward bridge wrong");
    a_brake_bridge: assert property (wr_ff && d[1:0] == 2'h3 |-> ##2 br == 4'h5)
        else $error("brake bridge wrong");
    a_float_bridge: assert property (wr_ff && d[1:0] == 2'h0 |-> ##2 br == 4'h0)
        else $error("float bridge wrong");
    a_head_run: assert property (wr_ff && d[3] |-> ##2 head_motor_drive_out && !head_motor_brake_out)
        else $error("head motor not driven");
    a_head_brake: assert property (wr_ff && !d[3] |-> ##2 head_motor_brake_out && !head_motor_drive_out)
        else $error("head motor not braked");
    a_erase_level: assert property ($past(wr_ff, 2) |-> erase_drive_out == !$past(d[4], 2))
        else $error("erase level wrong");
    a_wcur_flip: assert property (wr_ff && d[5] != wb_ff |-> ##2 $changed(write_current_dir_out))
        else $error("write current kept");
    a_count_pulse: assert property ($rose(reel_mirror_in) |-> ##[1:4] tape_count_pulse_out)
        else $error("count pulse missing");
    c_fwd: cover property (wr_ff && d[1:0] == 2'h1);
    c_count: cover property (tape_count_pulse_out);
    c_flip: cover property ($changed(write_current_dir_out));
endmodule
bind ctc_transport ctc_transport_props ctc_transport_props_i (.clk_sys_in, .rst_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .reel_mirror_in, .capstan_pos_hi_out, .capstan_pos_lo_out,
    .capstan_neg_hi_out, .capstan_neg_lo_out, .head_motor_drive_out, .head_motor_brake_out, .erase_drive_out,
    .write_current_dir_out, .tape_count_pulse_out);

// [sim/ctc_mech_model.sv]
// Mechanism model: tachometer, reel mirrors and head cam
`timescale 1ns/1ns
module ctc_mech_model (
    input  wire logic        clk_sys_in,
    input  wire logic [15:0] tacho_per_in,
    input  wire logic        fwd_in,
    input  wire logic        head_in,
    output logic             tacho_out = 1'b0,
    output logic             mirror_out = 1'b0,
    output logic             cam_out = 1'b0,
    output int               mirrors_out = 0
);
    int tc = 0;
    int mc = 0;
    int hc = 0;
    always @(posedge clk_sys_in) begin
        tc <= (tc + 1 >= tacho_per_in) ? 0 : tc + 1;
        tacho_out <= (tc < tacho_per_in / 2);
        if (fwd_in)
            mc <= (mc + 1) % 160;
        mirror_out <= fwd_in && (mc % 40 < 20);
        if (fwd_in && mc % 40 < 20 && !mirror_out)
            mirrors_out <= mirrors_out + 1;
        if (head_in)
            hc <= hc + 1;
        cam_out <= hc[5];
    end
endmodule

// [sim/test_cassette_transport_control.sv]
// Self-checking bench for the cassette transport control
`timescale 1ns/1ns
module test_cassette_transport_control;
    import ctc_pkg::*;
    typedef struct {ctc_word_t e; ctc_word_t m;} ctc_note_s;
    ctc_note_s   q[$];
    logic        clk_sys_in, rst_in, hsel_in, hwrite_in, hready_in, rd_dp, dir, wb;
    logic [1:0]  htrans_in;
    logic [2:0]  hsize_in;
    logic [7:0]  v;
    logic [7:0]  blk [256];
    logic [15:0] per;
    logic [31:0] haddr_in, r;
    ctc_word_t   hwdata_in, hrdata_out;
    logic        hreadyout_out, hresp_out, tacho_in, reel_mirror_in, head_cam_in, capstan_pos_hi_out;
    logic        capstan_pos_lo_out, capstan_neg_hi_out, capstan_neg_lo_out, capstan_supply_out;
    logic        head_motor_drive_out, head_motor_brake_out, erase_drive_out, write_current_dir_out;
    logic        tape_count_pulse_out, head_position_switch_out;
    int          n_errors = 0, n_compared = 0, seed = 50, mirrors, n0, t;
    assign hready_in = hreadyout_out;
    ctc_transport #(.TACHO_CYC(100), .TACHO_TOL(10)) ctc_transport_i (.clk_sys_in, .rst_in, .hsel_in,
        .haddr_in, .htrans_in, .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out,
        .hresp_out, .tacho_in, .reel_mirror_in, .head_cam_in, .capstan_pos_hi_out, .capstan_pos_lo_out,
        .capstan_neg_hi_out, .capstan_neg_lo_out, .capstan_supply_out, .head_motor_drive_out,
        .head_motor_brake_out, .erase_drive_out, .write_current_dir_out, .tape_count_pulse_out,
        .head_position_switch_out);
    ctc_mech_model ctc_mech_model_i (.clk_sys_in, .tacho_per_in(per), .head_in(head_motor_drive_out),
        .fwd_in(capstan_pos_hi_out & capstan_neg_lo_out), .tacho_out(tacho_in), .mirror_out(reel_mirror_in),
        .cam_out(head_cam_in), .mirrors_out(mirrors));
    task automatic check(input ctc_word_t seen, input ctc_word_t exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // A read notes its expected word; d is write data or expected read data
    task automatic xfer(input logic w, input logic [7:0] a, input ctc_word_t d, input ctc_word_t m);
        if (!w)
            q.push_back('{d, m});
        @(posedge clk_sys_in);
        htrans_in <= 2'h2;
        haddr_in  <= {24'h0, a};
        hwrite_in <= w;
        do @(posedge clk_sys_in); while (hready_in !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        rd_dp     <= !w;
        do @(posedge clk_sys_in); while (hready_in !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    // eight data bits, then the stop bit
    task automatic send_byte(input logic [7:0] b);
        for (int k = 0; k < 9; k++) begin
            wb  = ~wb;
            dir = ~dir;
            // first line only, regulated, erase on
            xfer(1, 8'h00, {24'h0, 2'b01, wb, 5'h01}, 0);
            // one and stop long, zero short
            repeat ((k == 8 || b[k]) ? 5 : 1) @(posedge clk_sys_in);
        end
    endtask
    always @(posedge clk_sys_in) begin
        if (rd_dp && hready_in && q.size() > 0) begin
            check(hrdata_out & q[0].m, q[0].e);
            void'(q.pop_front());
        end
    end
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #700000;
        n_errors++;
        wrap_up;
    end
    initial begin
        {rst_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in, rd_dp, dir, wb} = '0;
        rst_in   = 1'b1;
        hsel_in  = 1'b1;
        hsize_in = 3'h2;
        per      = 16'd100;
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        xfer(0, 8'h00, 32'h10, 32'hFF);
        xfer(0, 8'h14, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            v = (r[7:0] & 8'h38) | 8'(i % 4);
            dir = dir ^ (r[5] ^ wb);
            wb = r[5];
            xfer(1, 8'h00, {24'h0, v}, 0);
            xfer(0, 8'h04, {24'h0, r[3], dir, 2'h0, 4'h1 << ((i + 3) % 4)}, 32'hCF);
        end
        dir = dir ^ wb;
        wb  = 1'b0;
        xfer(1, 8'h00, 32'h90, 0);
        xfer(1, 8'h00, 32'h10, 0);
        n0 = mirrors;
        xfer(1, 8'h00, 32'h11, 0);
        repeat (400) @(posedge clk_sys_in);
        xfer(1, 8'h00, 32'h10, 0);
        repeat (10) @(posedge clk_sys_in);
        xfer(0, 8'h0C, mirrors - n0, 32'hFFFFFFFF);
        xfer(1, 8'h00, 32'h51, 0);
        repeat (500) @(posedge clk_sys_in);
        xfer(0, 8'h08, 32'd100, 32'hFFFFFFFF);
        xfer(0, 8'h04, 32'h20, 32'h20);
        per <= 16'd60;
        repeat (400) @(posedge clk_sys_in);
        xfer(0, 8'h08, 32'd60, 32'hFFFFFFFF);
        xfer(0, 8'h04, 32'h0, 32'h20);
        check({31'h0, capstan_supply_out}, 32'h0);
        xfer(1, 8'h00, 32'h55, 0);
        repeat (3) @(posedge clk_sys_in);
        check({31'h0, capstan_supply_out}, 32'h1);
        // load the head, release at the switch
        per <= 16'd100;
        xfer(1, 8'h00, {24'h0, 2'b01, wb, 5'h19}, 0);
        for (int s = 0; s < 2; s++) begin
            t = 0;
            while (head_position_switch_out !== 1'(s) && t < 300) begin
                @(posedge clk_sys_in);
                t++;
            end
        end
        xfer(1, 8'h00, {24'h0, 2'b01, wb, 5'h11}, 0);
        repeat (100) @(posedge clk_sys_in);
        xfer(0, 8'h04, 32'h11, 32'h9F);
        check({31'h0, head_position_switch_out}, 32'h1);
        for (int n = 0; n < 256; n++) begin
            r = $random(seed);
            blk[n] = r[7:0];
        end
        // erase on before the first bit
        xfer(1, 8'h00, {24'h0, 2'b01, wb, 5'h01}, 0);
        for (int p = 0; p < 512; p++) begin
            send_byte(blk[p % 256]);
        end
        check({31'h0, erase_drive_out}, 32'h1);
        repeat (3) @(posedge clk_sys_in);
        check({31'h0, write_current_dir_out}, {31'h0, dir});
        wrap_up;
    end
endmodule
